/* rtl/ssc_pkg.sv */
// shared constants, types and checksum helpers for the sensor status link
package ssc_pkg;

  typedef logic [15:0] ssc_word_t;

  // bus addressing
  localparam logic [6:0]  DEV_ADDR      = 7'h44;
  localparam logic [7:0]  GC_ADDR       = 8'h00;
  localparam logic [7:0]  GC_RESET      = 8'h06;

  // 16-bit commands
  localparam ssc_word_t   CMD_CLEAR     = 16'h3041;
  localparam ssc_word_t   CMD_HEAT_ON   = 16'h306D;
  localparam ssc_word_t   CMD_HEAT_OFF  = 16'h3066;
  localparam ssc_word_t   CMD_STAT_RD   = 16'h30A5;

  // status word field positions and reset value
  localparam int          B_ALERT       = 15;
  localparam int          B_HEAT        = 13;
  localparam int          B_RHAL        = 11;
  localparam int          B_TAL         = 10;
  localparam int          B_RST         = 4;
  localparam int          B_CMD         = 1;
  localparam int          B_WR          = 0;
  localparam ssc_word_t   STAT_RST      = 16'h8010;

  // checksum
  localparam logic [7:0]  CRC_POLY      = 8'h31;
  localparam logic [7:0]  CRC_INIT      = 8'hFF;
  localparam logic [7:0]  CRC_XOR       = 8'h00;
  localparam logic [7:0]  FILL_BYTE     = 8'hFF;

  // controller register map
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_WDATA     = 8'h04;
  localparam logic [7:0]  REG_STAT      = 8'h08;
  localparam logic [7:0]  REG_RXW       = 8'h0C;
  localparam logic [7:0]  REG_RH        = 8'h10;
  localparam logic [7:0]  REG_TC        = 8'h14;
  localparam logic [7:0]  REG_TF        = 8'h18;

  // controller operations and their byte counts
  localparam logic [1:0]  OP_CMD        = 2'h0;
  localparam logic [1:0]  OP_CMDDATA    = 2'h1;
  localparam logic [1:0]  OP_GCRST      = 2'h2;
  localparam logic [1:0]  OP_READ       = 2'h3;
  localparam logic [2:0]  LEN_CMD       = 3'h3;
  localparam logic [2:0]  LEN_CMDDATA   = 3'h6;
  localparam logic [2:0]  LEN_GCRST     = 3'h2;
  localparam logic [2:0]  LEN_READ      = 3'h4;

  // link timing
  localparam int          CLK_MHZ       = 40;
  localparam int          SCL_PERIOD_NS = 2500;
  localparam int          SCL_QUARTER_CYC = SCL_PERIOD_NS * CLK_MHZ / 4000;

  // physical scaling
  localparam int          FULL_SCALE    = 65535;
  localparam int          RH_SPAN       = 100;
  localparam int          T_SPAN_C      = 175;
  localparam int          T_OFS_C       = -45;
  localparam int          T_SPAN_F      = 315;
  localparam int          T_OFS_F       = -49;

  function automatic logic [7:0] ssc_crc8(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] ssc_crc_word(input ssc_word_t w);
    return ssc_crc8(ssc_crc8(CRC_INIT, w[15:8]), w[7:0]) ^ CRC_XOR;
  endfunction

endpackage

/* rtl/ssc_link_if.sv */
// two-wire link between sensor and controller, open-drain resolution
`timescale 1ns/1ps
`default_nettype none
interface ssc_link_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = ~(sclOe & ~sclOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

  modport dev (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
                output sdaHostOut, output sdaHostOe);
endinterface
`default_nettype wire

/* rtl/ssc_sensor_dev.sv */
// sensor end: status word, command decode and checksummed link slave
// Behaviour
// - bit 15 flags pending alerts, resets to one
// - bit 13 mirrors heater state, default off
// - bits 11, 10 flag humidity, temperature alerts
// - bit 4 set by any reset until cleared
// - bit 1 flags last command rejected
// - bit 0 flags last write checksum failure
// - clear command zeroes bits 15, 11, 10, 4
// - checksum byte follows each sent word
// - checksum poly 31, init FF, no reflection
// - both directions of data are checksummed
// - results are unsigned compensated 16-bit words
// - controller scales humidity by 100 over 65535
// - controller scales temperature to Celsius, Fahrenheit
// - heater on/off commands; heater off after reset
// - general call 06 performs soft reset
`timescale 1ns/1ps
`default_nettype none
module ssc_sensor_dev (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  ssc_link_if.dev                link,
  input  wire logic              rhAlertEvt,
  input  wire logic              tAlertEvt,
  input  wire logic              supplyFailEvt,
  output var  logic              heaterOn,
  output var  logic              softResetPulse,
  output var  ssc_pkg::ssc_word_t statusWord
);
  import ssc_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RX   = 2'b01,
    D_TX   = 2'b11,
    D_SKIP = 2'b10
  } ssc_dev_state_t;

  typedef struct packed {
    logic           scl1;
    logic           scl2;
    logic           scl3;
    logic           sda1;
    logic           sda2;
    logic           sda3;
    ssc_dev_state_t st;
    logic [3:0]     bitCnt;
    logic [2:0]     byteCnt;
    logic [7:0]     sh;
    logic           isRead;
    logic           isGc;
    logic           nackd;
    logic           sdaLow;
    ssc_word_t      cmd;
    ssc_word_t      dat;
    logic [7:0]     crcIn;
    ssc_word_t      snap;
    logic           alertPend;
    logic           heater;
    logic           rhAl;
    logic           tAl;
    logic           rstDet;
    logic           cmdErr;
    logic           wrErr;
    logic           softRst;
  } ssc_dev_t;

  ssc_dev_t  r_reg;
  ssc_dev_t  r_next;
  logic      sclRise;
  logic      sclFall;
  logic      startCond;
  logic      stopCond;
  ssc_word_t statNow;

  function automatic logic ssc_cmd_known(input ssc_word_t c);
    return c == CMD_CLEAR || c == CMD_HEAT_ON || c == CMD_HEAT_OFF ||
           c == CMD_STAT_RD;
  endfunction

  // byte k of a status answer
  function automatic logic [7:0] ssc_tx_byte(input ssc_word_t s,
                                             input logic [2:0] k);
    logic [7:0] b;
    b = FILL_BYTE;
    case (k)
      3'h0: b = s[15:8];
      3'h1: b = s[7:0];
      // checksum over the two bytes just sent
      3'h2: b = ssc_crc_word(s);
      default: b = FILL_BYTE;
    endcase
    return b;
  endfunction

  always_comb begin
    statNow         = '0;
    statNow[B_ALERT] = r_reg.alertPend;
    statNow[B_HEAT] = r_reg.heater;
    statNow[B_RHAL] = r_reg.rhAl;
    statNow[B_TAL]  = r_reg.tAl;
    statNow[B_RST]  = r_reg.rstDet;
    statNow[B_CMD]  = r_reg.cmdErr;
    statNow[B_WR]   = r_reg.wrErr;
  end

  always_comb begin
    r_next         = r_reg;
    r_next.softRst = 1'b0;
    r_next.scl1    = link.scl;
    r_next.scl2    = r_reg.scl1;
    r_next.scl3    = r_reg.scl2;
    r_next.sda1    = link.sda;
    r_next.sda2    = r_reg.sda1;
    r_next.sda3    = r_reg.sda2;
    sclRise   = r_reg.scl2 & ~r_reg.scl3;
    sclFall   = ~r_reg.scl2 & r_reg.scl3;
    startCond = r_reg.scl2 & r_reg.scl3 & ~r_reg.sda2 & r_reg.sda3;
    stopCond  = r_reg.scl2 & r_reg.scl3 & r_reg.sda2 & ~r_reg.sda3;
    if (startCond) begin
      r_next.st      = D_RX;
      // F marks the clock fall that closes the start condition
      r_next.bitCnt  = 4'hF;
      r_next.byteCnt = 3'h0;
      r_next.isRead  = 1'b0;
      r_next.isGc    = 1'b0;
      r_next.nackd   = 1'b0;
      r_next.sdaLow  = 1'b0;
    end else if (stopCond) begin
      if (r_reg.st == D_RX && r_reg.isGc) begin
        // soft reset on general call 06
        if (r_reg.byteCnt == 3'h2 && r_reg.cmd[7:0] == GC_RESET) begin
          r_next.alertPend = STAT_RST[B_ALERT];
          r_next.heater    = STAT_RST[B_HEAT];
          r_next.rhAl      = STAT_RST[B_RHAL];
          r_next.tAl       = STAT_RST[B_TAL];
          r_next.rstDet    = STAT_RST[B_RST];
          r_next.cmdErr    = STAT_RST[B_CMD];
          r_next.wrErr     = STAT_RST[B_WR];
          r_next.softRst   = 1'b1;
        end
      end else if (r_reg.st == D_RX && r_reg.byteCnt == 3'h3) begin
        r_next.cmdErr = ~ssc_cmd_known(r_reg.cmd);
        if (r_reg.cmd == CMD_CLEAR) begin
          r_next.alertPend = 1'b0;
          r_next.rhAl      = 1'b0;
          r_next.tAl       = 1'b0;
          r_next.rstDet    = 1'b0;
        end
        if (r_reg.cmd == CMD_HEAT_ON) begin
          r_next.heater = 1'b1;
        end
        if (r_reg.cmd == CMD_HEAT_OFF) begin
          r_next.heater = 1'b0;
        end
      end else if (r_reg.st == D_RX && r_reg.byteCnt == 3'h6) begin
        r_next.wrErr = ssc_crc_word(r_reg.dat) != r_reg.crcIn;
      end else if (r_reg.st == D_RX && r_reg.byteCnt > 3'h1) begin
        r_next.cmdErr = 1'b1;
      end
      r_next.st     = D_IDLE;
      r_next.sdaLow = 1'b0;
    end else if (r_reg.st == D_RX || r_reg.st == D_TX) begin
      if (sclRise && r_reg.bitCnt < 4'h8 && r_reg.st == D_RX) begin
        r_next.sh = {r_reg.sh[6:0], r_reg.sda2};
      end
      if (sclRise && r_reg.bitCnt == 4'h8 && r_reg.st == D_TX) begin
        r_next.nackd = r_reg.sda2;
      end
      if (sclFall) begin
        if (r_reg.bitCnt == 4'hF) begin
          r_next.bitCnt = 4'h0;
        end else if (r_reg.bitCnt < 4'h7) begin
          r_next.bitCnt = r_reg.bitCnt + 4'h1;
          if (r_reg.st == D_TX) begin
            r_next.sh     = {r_reg.sh[6:0], 1'b0};
            r_next.sdaLow = ~r_reg.sh[6];
          end
        end else if (r_reg.bitCnt == 4'h7) begin
          r_next.bitCnt = 4'h8;
          r_next.sdaLow = 1'b0;
          if (r_reg.st == D_RX && r_reg.byteCnt == 3'h0) begin
            if (r_reg.sh[7:1] == DEV_ADDR) begin
              r_next.sdaLow = 1'b1;
              r_next.isRead = r_reg.sh[0];
            end else if (r_reg.sh == GC_ADDR) begin
              r_next.sdaLow = 1'b1;
              r_next.isGc   = 1'b1;
            end else begin
              r_next.st = D_SKIP;
            end
          end else if (r_reg.st == D_RX) begin
            r_next.sdaLow = r_reg.byteCnt < LEN_CMDDATA;
            if (r_reg.byteCnt < 3'h3) begin
              r_next.cmd = {r_reg.cmd[7:0], r_reg.sh};
            end else if (r_reg.byteCnt < 3'h5) begin
              r_next.dat = {r_reg.dat[7:0], r_reg.sh};
            end else begin
              r_next.crcIn = r_reg.sh;
            end
          end
        end else begin
          r_next.bitCnt  = 4'h0;
          r_next.sdaLow  = 1'b0;
          r_next.byteCnt = (r_reg.byteCnt == 3'h7) ? r_reg.byteCnt
                                                   : r_reg.byteCnt + 3'h1;
          if (r_reg.st == D_RX && r_reg.isRead) begin
            r_next.st     = D_TX;
            r_next.snap   = statNow;
            r_next.sh     = ssc_tx_byte(statNow, 3'h0);
            r_next.sdaLow = ~statNow[15];
          end else if (r_reg.st == D_TX && r_reg.nackd) begin
            r_next.st = D_SKIP;
          end else if (r_reg.st == D_TX) begin
            r_next.sh     = ssc_tx_byte(r_reg.snap, r_reg.byteCnt);
            r_next.sdaLow = ~r_next.sh[7];
          end
        end
      end
    end
    // alert events win over a same-cycle clear
    if (rhAlertEvt) begin
      r_next.rhAl      = 1'b1;
      r_next.alertPend = 1'b1;
    end
    if (tAlertEvt) begin
      r_next.tAl       = 1'b1;
      r_next.alertPend = 1'b1;
    end
    if (supplyFailEvt) begin
      r_next.rstDet = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.alertPend <= STAT_RST[B_ALERT];
      r_reg.heater    <= STAT_RST[B_HEAT];
      r_reg.rstDet    <= STAT_RST[B_RST];
    end else begin
      r_reg <= r_next;
    end
  end

  // words leave unsigned, no scaling inside the sensor
  assign link.sdaDevOut  = 1'b0;
  assign link.sdaDevOe   = r_reg.sdaLow;
  assign heaterOn        = r_reg.heater;
  assign softResetPulse  = r_reg.softRst;
  assign statusWord      = statNow;
endmodule
`default_nettype wire

/* rtl/ssc_link_host.sv */
// controller end: register port, link master, checksum and scaling
`timescale 1ns/1ps
`default_nettype none
module ssc_link_host #(
  parameter int unsigned QUARTER_CYC = ssc_pkg::SCL_QUARTER_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  ssc_link_if.host         link,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [31:0] regRdata
);
  import ssc_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b11,
    H_STOP  = 2'b10
  } ssc_host_state_t;

  typedef struct packed {
    logic              sda1;
    logic              sda2;
    ssc_host_state_t   st;
    logic [1:0]        q;
    logic [7:0]        div;
    logic [3:0]        bitIdx;
    logic [2:0]        byteIdx;
    logic [2:0]        nBytes;
    logic [1:0]        op;
    ssc_word_t         cmd;
    ssc_word_t         dat;
    logic [7:0]        sh;
    logic              nack;
    logic              crcErr;
    ssc_word_t         rxWord;
    logic [7:0]        rh;
    logic signed [9:0] tC;
    logic signed [9:0] tF;
    logic [31:0]       rdata;
  } ssc_host_t;

  ssc_host_t r_reg;
  ssc_host_t r_next;
  logic      tick;
  logic      isTx;
  logic      sclLevel;
  logic      sdaLevel;

  function automatic logic [7:0] ssc_host_byte(input logic [1:0] op,
                                               input logic [2:0] idx,
                                               input ssc_word_t c,
                                               input ssc_word_t d);
    logic [7:0] b;
    b = FILL_BYTE;
    case (idx)
      3'h0: b = (op == OP_GCRST) ? GC_ADDR : {DEV_ADDR, op == OP_READ};
      3'h1: b = (op == OP_GCRST) ? GC_RESET : c[15:8];
      3'h2: b = c[7:0];
      3'h3: b = d[15:8];
      3'h4: b = d[7:0];
      // checksum on the written data word
      3'h5: b = ssc_crc_word(d);
      default: b = FILL_BYTE;
    endcase
    return b;
  endfunction

  always_comb begin
    r_next       = r_reg;
    r_next.sda1  = link.sda;
    r_next.sda2  = r_reg.sda1;
    r_next.rdata = '0;
    tick = r_reg.div == 8'(QUARTER_CYC - 1);
    isTx = !(r_reg.op == OP_READ && r_reg.byteIdx != 3'h0);
    if (regRd) begin
      if (regAddr == REG_CTRL) begin
        r_next.rdata = {14'h0, r_reg.op, r_reg.cmd};
      end else if (regAddr == REG_WDATA) begin
        r_next.rdata = {16'h0, r_reg.dat};
      end else if (regAddr == REG_STAT) begin
        r_next.rdata = {29'h0, r_reg.crcErr, r_reg.nack,
                        r_reg.st != H_IDLE};
      end else if (regAddr == REG_RXW) begin
        r_next.rdata = {16'h0, r_reg.rxWord};
      end else if (regAddr == REG_RH) begin
        r_next.rdata = {24'h0, r_reg.rh};
      end else if (regAddr == REG_TC) begin
        r_next.rdata = {{22{r_reg.tC[9]}}, r_reg.tC};
      end else if (regAddr == REG_TF) begin
        r_next.rdata = {{22{r_reg.tF[9]}}, r_reg.tF};
      end
    end
    if (regWr && regAddr == REG_WDATA) begin
      r_next.dat = regWdata[15:0];
    end
    if (r_reg.st == H_IDLE) begin
      r_next.div = 8'h00;
      r_next.q   = 2'h0;
      if (regWr && regAddr == REG_CTRL) begin
        r_next.op     = regWdata[17:16];
        r_next.cmd    = regWdata[15:0];
        r_next.nack   = 1'b0;
        r_next.crcErr = 1'b0;
        r_next.st     = H_START;
        case (regWdata[17:16])
          OP_CMD:     r_next.nBytes = LEN_CMD;
          OP_CMDDATA: r_next.nBytes = LEN_CMDDATA;
          OP_GCRST:   r_next.nBytes = LEN_GCRST;
          default:    r_next.nBytes = LEN_READ;
        endcase
      end
    end else begin
      r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
      if (tick) begin
        r_next.q = r_reg.q + 2'h1;
        case (r_reg.st)
          H_START: begin
            if (r_reg.q == 2'h3) begin
              r_next.st      = H_BIT;
              r_next.bitIdx  = 4'h0;
              r_next.byteIdx = 3'h0;
              r_next.sh = ssc_host_byte(r_reg.op, 3'h0, r_reg.cmd,
                                        r_reg.dat);
            end
          end
          H_BIT: begin
            if (r_reg.q == 2'h2 && r_reg.bitIdx != 4'h8 && !isTx) begin
              r_next.sh = {r_reg.sh[6:0], r_reg.sda2};
            end
            if (r_reg.q == 2'h2 && r_reg.bitIdx == 4'h8) begin
              if (isTx) begin
                r_next.nack = r_reg.sda2;
              end else if (r_reg.byteIdx == 3'h1) begin
                r_next.rxWord[15:8] = r_reg.sh;
              end else if (r_reg.byteIdx == 3'h2) begin
                r_next.rxWord[7:0] = r_reg.sh;
              end else begin
                r_next.crcErr = ssc_crc_word(r_reg.rxWord) != r_reg.sh;
              end
            end
            if (r_reg.q == 2'h3 && r_reg.bitIdx != 4'h8) begin
              r_next.bitIdx = r_reg.bitIdx + 4'h1;
              if (isTx) begin
                r_next.sh = {r_reg.sh[6:0], 1'b0};
              end
            end else if (r_reg.q == 2'h3) begin
              if (r_reg.nack || r_reg.byteIdx == r_reg.nBytes - 3'h1) begin
                r_next.st = H_STOP;
              end else begin
                r_next.byteIdx = r_reg.byteIdx + 3'h1;
                r_next.bitIdx  = 4'h0;
                r_next.sh = ssc_host_byte(r_reg.op, r_reg.byteIdx + 3'h1,
                                          r_reg.cmd, r_reg.dat);
              end
            end
          end
          H_STOP: begin
            if (r_reg.q == 2'h3) begin
              r_next.st = H_IDLE;
              if (r_reg.op == OP_READ && !r_reg.nack && !r_reg.crcErr) begin
                r_next.rh = 8'(int'(r_reg.rxWord) * RH_SPAN / FULL_SCALE);
                r_next.tC = 10'(T_OFS_C +
                                int'(r_reg.rxWord) * T_SPAN_C / FULL_SCALE);
                r_next.tF = 10'(T_OFS_F +
                                int'(r_reg.rxWord) * T_SPAN_F / FULL_SCALE);
              end
            end
          end
          default: r_next.st = H_IDLE;
        endcase
      end
    end
  end

  // pin levels per quarter of a bit
  always_comb begin
    sclLevel = 1'b1;
    sdaLevel = 1'b1;
    case (r_reg.st)
      H_START: begin
        sclLevel = r_reg.q != 2'h3;
        sdaLevel = r_reg.q == 2'h0;
      end
      H_BIT: begin
        sclLevel = r_reg.q[1];
        if (r_reg.bitIdx != 4'h8) begin
          sdaLevel = isTx ? r_reg.sh[7] : 1'b1;
        end else begin
          sdaLevel = isTx || r_reg.byteIdx == r_reg.nBytes - 3'h1;
        end
      end
      H_STOP: begin
        sclLevel = r_reg.q != 2'h0;
        sdaLevel = r_reg.q[1];
      end
      default: begin
        sclLevel = 1'b1;
        sdaLevel = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sclOut     = 1'b0;
  assign link.sclOe      = ~sclLevel;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = ~sdaLevel;
  assign regRdata        = r_reg.rdata;
endmodule
`default_nettype wire

/* tb/ssc_props.sv */
// link wire and status word checks for the sensor status link
`timescale 1ns/1ps
`default_nettype none
module ssc_props #(
  parameter int unsigned QUARTER_CYC = 4
) (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        sclOut,
  input wire logic        sclOe,
  input wire logic        sdaHostOut,
  input wire logic        sdaHostOe,
  input wire logic        sdaDevOut,
  input wire logic        sdaDevOe,
  input wire logic        scl,
  input wire logic        sda,
  input wire logic [15:0] statusWord,
  input wire logic        heaterOn
);
  int unsigned hiCnt;
  int unsigned loCnt;

  // length of the current high and low stretch of the link clock
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      hiCnt <= 0;
      loCnt <= 0;
    end else begin
      hiCnt <= scl ? hiCnt + 1 : 0;
      loCnt <= scl ? 0 : loCnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_open_drain:
    assert property (!sclOut && !sdaHostOut && !sdaDevOut)
      else $error("link output driven high");
  chk_alert_sum:
    assert property ((statusWord[11] || statusWord[10]) |-> statusWord[15])
      else $error("alert flag without pending bit");
  chk_link_idle:
    assert property ($rose(rst_b) |-> !sclOe && !sdaHostOe && !sdaDevOe
      && scl && sda) else $error("link not idle after reset");
  chk_rst_value:
    assert property ($rose(rst_b) |-> statusWord == 16'h8010 && !heaterOn)
      else $error("status word wrong after reset");
  chk_heat_mirror:
    assert property (statusWord[13] == heaterOn)
      else $error("heater bit differs from heater state");
  chk_rsvd_zero:
    assert property (!statusWord[14] && !statusWord[12]
      && statusWord[3:2] == 2'h0) else $error("reserved bit set");
  chk_scl_high:
    assert property ($fell(scl) |-> hiCnt >= 2 * QUARTER_CYC)
      else $error("link clock high too short");
  chk_scl_low:
    assert property ($rose(scl) |-> loCnt >= QUARTER_CYC)
      else $error("link clock low too short");
  chk_scl_moves:
    assert property ($fell(scl) |-> ##[1:40] scl)
      else $error("link clock stuck low");
  chk_dev_hold:
    assert property ($fell(scl) |=> $stable(sdaDevOe)[*2])
      else $error("sensor data changed too early");
endmodule
`default_nettype wire

/* tb/sensor_status_and_crc_unit_bench.sv */
// bench: controller and sensor ends joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module sensor_status_and_crc_unit_bench;
  import ssc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [2:0]  evt = 3'h0;
  logic [31:0] regRdata;
  logic [31:0] rd;
  logic        heaterOn;
  logic        softResetPulse;
  ssc_word_t   statusWord;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          resetPulses = 0;

  ssc_link_if link ();
  ssc_link_host #(.QUARTER_CYC(4)) u_ssc_link_host (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  ssc_sensor_dev u_ssc_sensor_dev (
    .clk_sys(clk_sys), .rst_b(rst_b), .link(link), .rhAlertEvt(evt[2]),
    .tAlertEvt(evt[1]), .supplyFailEvt(evt[0]), .heaterOn(heaterOn),
    .softResetPulse(softResetPulse), .statusWord(statusWord));
  ssc_props #(.QUARTER_CYC(4)) u_ssc_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclOut(link.sclOut),
    .sclOe(link.sclOe), .sdaHostOut(link.sdaHostOut),
    .sdaHostOe(link.sdaHostOe), .sdaDevOut(link.sdaDevOut),
    .sdaDevOe(link.sdaDevOe), .scl(link.scl), .sda(link.sda),
    .statusWord(statusWord), .heaterOn(heaterOn));

  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (softResetPulse === 1'b1) resetPulses++;
  end

  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  // start a link operation and poll busy until it ends
  task automatic run(input logic [1:0] op, input ssc_word_t c);
    int n;
    wr(REG_CTRL, {14'h0, op, c});
    n = 0;
    do begin
      rdreg(REG_STAT, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (rd[0] !== 1'b0) begin
      check(rd, 32'h0);
      complete_run();
    end
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic pulse(input logic [2:0] e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= 3'h0;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(statusWord, STAT_RST);
    check(heaterOn, 1'b0);
    check(ssc_crc_word(16'hBEEF), 32'h92);
    run(OP_READ, CMD_STAT_RD);
    rdreg(REG_STAT, rd);
    check(rd[2:0], 3'h0);
    @(posedge clk_sys);
    #1;
    check(regRdata, 32'h0);
    rdreg(REG_RXW, rd);
    check(rd[15:0], STAT_RST);
    rdreg(REG_RH, rd);
    check(rd, 32'h32);
    $display("test status read done");
    run(OP_CMD, CMD_CLEAR);
    check(statusWord, 16'h0000);
    run(OP_READ, CMD_STAT_RD);
    rdreg(REG_TC, rd);
    check(rd[9:0], 10'h3D3);
    rdreg(REG_TF, rd);
    check(rd[9:0], 10'h3CF);
    $display("test scaling done");
    run(OP_CMD, CMD_HEAT_ON);
    check(statusWord, 16'h2000);
    pulse(3'h4);
    check(statusWord, 16'hA800);
    pulse(3'h2);
    check(statusWord, 16'hAC00);
    pulse(3'h1);
    check(statusWord, 16'hAC10);
    run(OP_CMD, CMD_CLEAR);
    check(statusWord, 16'h2000);
    $display("test alerts done");
    run(OP_CMD, 16'h1234);
    check(statusWord, 16'h2002);
    run(OP_CMD, CMD_HEAT_OFF);
    check(statusWord, 16'h0000);
    wr(REG_WDATA, 32'h0000BEEF);
    run(OP_CMDDATA, CMD_HEAT_ON);
    check(statusWord[0], 1'b0);
    $display("test command status done");
    run(OP_CMD, CMD_HEAT_ON);
    check(heaterOn, 1'b1);
    run(OP_GCRST, 16'h0000);
    check(statusWord, STAT_RST);
    check(resetPulses, 32'h1);
    check(heaterOn, 1'b0);
    run(OP_CMD, CMD_CLEAR);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check(statusWord, STAT_RST);
    rdreg(8'h1C, rd);
    check(rd, 32'h0);
    $display("test resets done");
    complete_run();
  end
endmodule
`default_nettype wire
